// file: include/sar_adc_pkg.sv
// Shared constants and carrier types for the converter control block
`default_nettype none
package sar_adc_pkg;

    // ---------------------------------------------------------------
    // Result format
    // ---------------------------------------------------------------
    localparam int          RESULT_BITS = 12;
    localparam int          NIBBLE_BITS = 4;
    localparam logic [11:0] SAR_RESET   = 12'h000;
    localparam logic [11:0] TRIAL_START = 12'h800;
    localparam logic [3:0]  BYTE_FILL   = 4'h0;

    // ---------------------------------------------------------------
    // Conversion timing, in converter clock falling edges
    // ---------------------------------------------------------------
    localparam int         EDGE_W          = 4;
    localparam logic [3:0] MSB_EDGE        = 4'h2;
    localparam logic [3:0] CONV_MIN_CYCLES = 4'hc;
    localparam logic [3:0] CONV_MAX_CYCLES = 4'hd;

    // ---------------------------------------------------------------
    // Host side timing, in ns and in system clock cycles
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 50;
    localparam int ACQUIRE_NS        = 1000;
    localparam int ACQUIRE_CYCLES    = (ACQUIRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_GAP_NS       = 200;
    localparam int READ_GAP_CYCLES   = (READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int START_GUARD_NS    = 40;
    localparam int START_GUARD_CYCLES =
        (START_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // Synchroniser vector layout and idle values
    // ---------------------------------------------------------------
    localparam int         SYNC_W      = 5;
    localparam int         SYNC_CS     = 4;
    localparam int         SYNC_RD     = 3;
    localparam int         SYNC_BYTE   = 2;
    localparam int         SYNC_CLK    = 1;
    localparam int         SYNC_CMP    = 0;
    localparam logic [4:0] SYNC_RESET  = 5'h18;

    // ---------------------------------------------------------------
    // Carrier types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic chipSelectN;
        logic readN;
        logic highByteSelect;
    } hostPins_t;

    typedef struct packed {
        logic [11:0] value;
        logic [11:0] enable;
    } dataBus_t;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_CONVERT
    } convState_t;

endpackage
`default_nettype wire

// file: logic/pin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Pin side
    input  wire logic [WIDTH-1:0] pinIn,
    // Clock domain side
    output var  logic [WIDTH-1:0] syncOut
);

    // ---------------------------------------------------------------
    // One pair of flops per bit
    // ---------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gSync
            logic meta_q;
            logic meta_d;
            logic stable_q;
            logic stable_d;

            // Next values: first stage only feeds the second
            always_comb begin
                meta_d   = pinIn[i];
                stable_d = meta_q;
            end

            // Register both stages
            always_ff @(posedge clk) begin
                if (reset) begin
                    meta_q   <= RESET_VAL[i];
                    stable_q <= RESET_VAL[i];
                end else begin
                    meta_q   <= meta_d;
                    stable_q <= stable_d;
                end
            end

            assign syncOut[i] = stable_q;
        end
    endgenerate

endmodule
`default_nettype wire

// file: logic/result_latch.sv
// Output latch holding the last finished conversion word
`timescale 1ns/10ps
`default_nettype none
module result_latch #(
    parameter int WIDTH = 12
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Write side
    input  wire logic             writeEn,
    input  wire logic [WIDTH-1:0] writeData,
    // Registered read side
    output var  logic [WIDTH-1:0] readData
);

    logic [WIDTH-1:0] word_q;
    logic [WIDTH-1:0] word_d;

    // Load only on a finished conversion
    always_comb begin
        word_d = word_q;
        if (writeEn) begin
            word_d = writeData;
        end
    end

    // Register the word
    always_ff @(posedge clk) begin
        if (reset) begin
            word_q <= '0;
        end else begin
            word_q <= word_d;
        end
    end

    assign readData = word_q;

endmodule
`default_nettype wire

// file: logic/sar_adc_bus_conversion_control.sv
// Bus control and approximation sequencing of a 12-bit sampling converter
//
// What this block does
// - Read low, select low, high byte low: start
// - High byte select high blocks conversion start
// - Data drivers enabled only while read, select low
// - Read ignored unless selected; byte select still picks the data layout
// - Busy output low throughout a running conversion
// - Conversion ends within twelve to thirteen clocks
// - Byte select low: full word, bit eleven top
// - Byte select high: top nibble twice, middle low
// - Bit eleven is MSB, bit zero LSB
// - Clock output is inverse of clock input
// - Start clears approximation register, enables outputs
// - Running conversion cannot be restarted
// - MSB after second falling edge, then per edge
// - Finished word moves into output latch
`timescale 1ns/10ps
`default_nettype none
module sar_adc_bus_conversion_control
    import sar_adc_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Host control pins
    input  wire hostPins_t              hostPins,
    // Converter clock pins
    input  wire logic                   convClockIn,
    output var  logic                   convClockOut,
    // Analog front end
    input  wire logic                   compareKeep,
    output var  logic [RESULT_BITS-1:0] dacCode,
    output var  logic                   holdSample,
    // Data bus and status
    output var  dataBus_t               dataBus,
    output var  logic                   busyN
);

    // ---------------------------------------------------------------
    // Input synchronisation
    // ---------------------------------------------------------------
    logic [SYNC_W-1:0] pinsRaw;
    logic [SYNC_W-1:0] pinsSync;

    assign pinsRaw = {hostPins.chipSelectN, hostPins.readN,
                      hostPins.highByteSelect, convClockIn, compareKeep};

    pin_sync #(
        .WIDTH     (SYNC_W),
        .RESET_VAL (SYNC_RESET)
    ) uSync (
        .clk     (clk),
        .reset   (reset),
        .pinIn   (pinsRaw),
        .syncOut (pinsSync)
    );

    logic csSync;
    logic rdSync;
    logic byteSync;
    logic clkSync;
    logic cmpSync;

    assign csSync   = pinsSync[SYNC_CS];
    assign rdSync   = pinsSync[SYNC_RD];
    assign byteSync = pinsSync[SYNC_BYTE];
    assign clkSync  = pinsSync[SYNC_CLK];
    assign cmpSync  = pinsSync[SYNC_CMP];

    // ---------------------------------------------------------------
    // Strobe decode and edge detection
    // ---------------------------------------------------------------
    logic readActive;
    logic readActive_q;
    logic convClk_q;
    logic convFall;
    logic startReq;

    // Strobe counts only while selected
    assign readActive = ~csSync & ~rdSync;
    // Falling edge of the converter clock
    assign convFall   = convClk_q & ~clkSync;

    // ---------------------------------------------------------------
    // Conversion sequencer state
    // ---------------------------------------------------------------
    convState_t              state_q;
    convState_t              state_d;
    logic [EDGE_W-1:0]       edgeCnt_q;
    logic [EDGE_W-1:0]       edgeCnt_d;
    logic [RESULT_BITS-1:0]  sar_q;
    logic [RESULT_BITS-1:0]  sar_d;
    logic [RESULT_BITS-1:0]  trial_q;
    logic [RESULT_BITS-1:0]  trial_d;
    logic                    busyN_q;
    logic                    busyN_d;
    logic                    latchWrite;
    logic [RESULT_BITS-1:0]  latchData;

    // New strobe edge with byte select low starts, only when idle
    assign startReq = readActive & ~readActive_q & ~byteSync
                    & (state_q == ST_IDLE);

    // Next sequencer values
    always_comb begin
        state_d    = state_q;
        edgeCnt_d  = edgeCnt_q;
        sar_d      = sar_q;
        trial_d    = trial_q;
        busyN_d    = busyN_q;
        latchWrite = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (startReq) begin
                    state_d   = ST_CONVERT;
                    edgeCnt_d = '0;
                    sar_d     = SAR_RESET;
                    trial_d   = TRIAL_START;
                    busyN_d   = 1'b0;
                end
            end
            ST_CONVERT: begin
                if (convFall) begin
                    edgeCnt_d = edgeCnt_q + 4'h1;
                    // Decisions from the second falling edge on
                    if (edgeCnt_q >= (MSB_EDGE - 4'h1)) begin
                        if (cmpSync) begin
                            sar_d = sar_q | trial_q;
                        end
                        trial_d = trial_q >> 1;
                        // LSB decided: finish and latch
                        if (trial_q[0]) begin
                            state_d    = ST_IDLE;
                            busyN_d    = 1'b1;
                            latchWrite = 1'b1;
                        end
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Register sequencer state
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q   <= ST_IDLE;
            edgeCnt_q <= '0;
            sar_q     <= SAR_RESET;
            trial_q   <= '0;
            busyN_q   <= 1'b1;
        end else begin
            state_q   <= state_d;
            edgeCnt_q <= edgeCnt_d;
            sar_q     <= sar_d;
            trial_q   <= trial_d;
            busyN_q   <= busyN_d;
        end
    end

    // ---------------------------------------------------------------
    // Output latch
    // ---------------------------------------------------------------
    result_latch #(
        .WIDTH (RESULT_BITS)
    ) uLatch (
        .clk       (clk),
        .reset     (reset),
        .writeEn   (latchWrite),
        .writeData (sar_d),
        .readData  (latchData)
    );

    // ---------------------------------------------------------------
    // Pin output registers
    // ---------------------------------------------------------------
    dataBus_t               bus_q;
    dataBus_t               bus_d;
    logic                   clkOut_q;
    logic                   clkOut_d;
    logic [RESULT_BITS-1:0] dac_q;
    logic [RESULT_BITS-1:0] dac_d;
    logic                   hold_q;
    logic                   hold_d;
    logic                   readActive_d;
    logic                   convClk_d;

    // Next pin values
    always_comb begin
        if (byteSync) begin
            bus_d.value = {latchData[11:8], BYTE_FILL, latchData[11:8]};
        end else begin
            bus_d.value = latchData;
        end
        bus_d.enable = {RESULT_BITS{readActive}};
        clkOut_d     = ~clkSync;
        dac_d        = sar_d | trial_d;
        hold_d       = ~busyN_d;
        readActive_d = readActive;
        convClk_d    = clkSync;
    end

    // Register pin values
    always_ff @(posedge clk) begin
        if (reset) begin
            bus_q        <= '0;
            clkOut_q     <= 1'b1;
            dac_q        <= '0;
            hold_q       <= 1'b0;
            readActive_q <= 1'b0;
            convClk_q    <= 1'b0;
        end else begin
            bus_q        <= bus_d;
            clkOut_q     <= clkOut_d;
            dac_q        <= dac_d;
            hold_q       <= hold_d;
            readActive_q <= readActive_d;
            convClk_q    <= convClk_d;
        end
    end

    assign dataBus      = bus_q;
    assign convClockOut = clkOut_q;
    assign dacCode      = dac_q;
    assign holdSample   = hold_q;
    assign busyN        = busyN_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    drivers_enable_a: assert property (
        bus_q.enable == {RESULT_BITS{$past(~hostPins.chipSelectN & ~hostPins.readN, 3)}})
        else $error("Data drivers on without select and read");

    start_clears_a: assert property (
        startReq |=> (sar_q == SAR_RESET) && !busyN_q && (trial_q == TRIAL_START))
        else $error("Start did not clear approximation register");

    byte_blocks_a: assert property (
        (state_q == ST_IDLE) && byteSync |=> busyN_q)
        else $error("Conversion started with byte select high");

    deselect_ignore_a: assert property (
        (state_q == ST_IDLE) && csSync |=> (state_q == ST_IDLE))
        else $error("Strobe acted while deselected");

    no_restart_a: assert property (
        (state_q == ST_CONVERT) && !convFall |=> $stable(trial_q) && $stable(sar_q))
        else $error("Running conversion disturbed");

    conv_length_a: assert property (
        $rose(busyN_q) |-> (edgeCnt_q >= CONV_MIN_CYCLES) && (edgeCnt_q <= CONV_MAX_CYCLES))
        else $error("Conversion length out of range");

    busy_tracks_a: assert property (
        busyN_q == (state_q == ST_IDLE))
        else $error("Busy does not match conversion state");

    latch_load_a: assert property (
        $rose(busyN_q) |=> latchData == $past(sar_q))
        else $error("Finished word not latched");

    latch_hold_a: assert property (
        !latchWrite |=> $stable(latchData))
        else $error("Latched word changed without conversion");

    high_byte_a: assert property (
        $past(byteSync) |-> (bus_q.value[7:4] == BYTE_FILL)
                            && (bus_q.value[11:8] == bus_q.value[3:0]))
        else $error("High byte layout wrong");

    full_word_a: assert property (
        !byteSync && $stable(latchData) |=> bus_q.value == $past(latchData))
        else $error("Full word not presented");

    clock_invert_a: assert property (
        ##1 convClockOut == !$past(clkSync))
        else $error("Clock output not inverted");

    start_enables_a: assert property (
        startReq |=> (bus_q.enable == {RESULT_BITS{1'b1}}) && (dac_q == TRIAL_START) && hold_q)
        else $error("Start did not enable outputs and first trial");

    msb_wait_a: assert property (
        (state_q == ST_CONVERT) && (edgeCnt_q < (MSB_EDGE - 4'h1)) |=> (trial_q == TRIAL_START))
        else $error("Top bit decided before second falling edge");

    bit_step_a: assert property (
        (state_q == ST_CONVERT) && convFall && (edgeCnt_q >= (MSB_EDGE - 4'h1))
        |=> (trial_q == ($past(trial_q) >> 1)))
        else $error("Trial bit did not step down one place");

endmodule
`default_nettype wire

// file: sim/analog_front_model.sv
// Far-side model: converter clock source and comparator on the held input
`timescale 1ns/10ps
`default_nettype none
module analog_front_model (
    // Clock
    input  wire logic        clk,
    // Converter side
    input  wire logic [11:0] dacCode,
    input  wire logic [11:0] sampleValue,
    output var  logic        compareKeep,
    output var  logic        convClockIn
);
    // ---------------------------------------------------------------
    // Converter clock
    // ---------------------------------------------------------------
    logic [1:0] divCount;

    // Free running clock, four system clocks per phase
    initial begin
        divCount = 2'h0;
        convClockIn = 1'b0;
        forever begin
            @(negedge clk);
            divCount = divCount + 2'h1;
            if (divCount == 2'h0) begin
                convClockIn = ~convClockIn;
            end
        end
    end

    // ---------------------------------------------------------------
    // Comparator
    // ---------------------------------------------------------------
    // Keep the trial bit while the trial level does not exceed the input
    assign compareKeep = (dacCode <= sampleValue);
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the converter bus control block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import sar_adc_pkg::*;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic        clk;
    logic        reset;
    hostPins_t   hostPins;
    logic        convClockIn;
    logic        convClockOut;
    logic        compareKeep;
    logic [11:0] dacCode;
    logic        holdSample;
    dataBus_t    dataBus;
    logic        busyN;
    logic [11:0] sampleValue;
    logic [2:0]  clkHist;
    logic        clkPrev;
    logic        clkCheck;
    int          fallEdges;
    int          failures;
    int          n_compared;

    // ---------------------------------------------------------------
    // Clock, design and far side
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    sar_adc_bus_conversion_control u_sar_adc_bus_conversion_control (
        .clk(clk), .reset(reset), .hostPins(hostPins), .convClockIn(convClockIn),
        .convClockOut(convClockOut), .compareKeep(compareKeep), .dacCode(dacCode),
        .holdSample(holdSample), .dataBus(dataBus), .busyN(busyN));

    analog_front_model u_analog_front_model (
        .clk(clk), .dacCode(dacCode), .sampleValue(sampleValue),
        .compareKeep(compareKeep), .convClockIn(convClockIn));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic setPins(input logic cs, input logic rd, input logic hb);
        @(negedge clk);
        hostPins.chipSelectN = cs;
        hostPins.readN = rd;
        hostPins.highByteSelect = hb;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic waitBusy(input logic level, input int limit);
        int n;
        n = 0;
        while (busyN !== level && n < limit) begin
            @(negedge clk);
            n++;
        end
        if (busyN !== level) begin
            failures++;
            $display("CHECK FAILED at %0t: busy wait ran out", $time);
            wrap_up();
        end
    endtask

    // Start one system clock after a converter clock edge, clear of the next
    task automatic alignStart();
        logic last;
        int   n;
        @(posedge clk);
        last = convClockIn;
        n = 0;
        while (convClockIn === last && n < 8) begin
            @(posedge clk);
            n++;
        end
    endtask

    // Falling converter clock edges while busy; inverted clock output lag
    always @(posedge clk) begin
        if (busyN === 1'b0 && clkPrev === 1'b1 && convClockIn === 1'b0) begin
            fallEdges = fallEdges + 1;
        end
        clkPrev = convClockIn;
        if (clkCheck) begin
            check(convClockOut === ~clkHist[2], "clock output not inverted");
        end
        clkHist = {clkHist[1:0], convClockIn};
    end

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    // Read strobe while deselected, byte select low, must do nothing
    task automatic deselected();
        setPins(1'b1, 1'b0, 1'b0);
        idle(8);
        check(busyN === 1'b1, "start while deselected");
        check(dataBus.enable === 12'h000, "drivers on while deselected");
        setPins(1'b1, 1'b1, 1'b0);
        idle(4);
    endtask

    // Full conversion; old word must stay readable; optional restart attempt
    task automatic convert(input logic [11:0] sample, input logic poke,
                           input logic [11:0] prevWord);
        sampleValue = sample;
        fallEdges = 0;
        alignStart();
        setPins(1'b0, 1'b0, 1'b0);
        waitBusy(1'b0, 8);
        check(dataBus.enable === 12'hfff, "drivers off at start");
        check(dacCode === TRIAL_START, "first trial not the top bit");
        check(holdSample === 1'b1, "hold not raised");
        idle(2);
        check(dataBus.value === prevWord, "old word not on bus");
        setPins(1'b0, 1'b1, 1'b0);
        idle(READ_GAP_CYCLES);
        if (poke) begin
            setPins(1'b0, 1'b0, 1'b0);
            idle(4);
            setPins(1'b0, 1'b1, 1'b0);
        end
        check(busyN === 1'b0, "busy ended early");
        waitBusy(1'b1, 200);
        check(holdSample === 1'b0, "hold not released");
        check(fallEdges >= 12 && fallEdges <= 13, "conversion length wrong");
        check(dataBus.enable === 12'h000, "drivers on after read");
        idle(ACQUIRE_CYCLES);
    endtask

    // High byte read: no start, top nibble twice, middle low
    task automatic readHigh(input logic [11:0] word);
        setPins(1'b0, 1'b0, 1'b1);
        idle(4);
        check(dataBus.enable === 12'hfff, "drivers off in read");
        check(dataBus.value === {word[11:8], BYTE_FILL, word[11:8]}, "high byte form");
        check(busyN === 1'b1, "high byte read started");
        setPins(1'b0, 1'b1, 1'b1);
        idle(5);
        check(dataBus.enable === 12'h000, "drivers held after read");
        idle(READ_GAP_CYCLES);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        failures = 0;
        n_compared = 0;
        fallEdges = 0;
        clkHist = 3'h0;
        clkPrev = 1'b0;
        clkCheck = 1'b0;
        reset = 1'b1;
        hostPins.chipSelectN = 1'b1;
        hostPins.readN = 1'b1;
        hostPins.highByteSelect = 1'b0;
        sampleValue = 12'h000;
        idle(10);
        reset = 1'b0;
        idle(4);
        clkCheck = 1'b1;
        check(busyN === 1'b1 && dataBus.enable === 12'h000, "idle state");
        deselected();
        convert(12'h801, 1'b0, 12'h000);
        readHigh(12'h801);
        convert(12'h5a3, 1'b1, 12'h801);
        readHigh(12'h5a3);
        convert(12'h000, 1'b0, 12'h5a3);
        convert(12'hfff, 1'b0, 12'h000);
        readHigh(12'hfff);
        deselected();
        wrap_up();
    end
endmodule
`default_nettype wire
